// ===== logic/iosad_decoder.sv
// i/o space address decoder between the core and the peripheral registers
// Functional notes
// - every peripheral location is reachable by data-space loads and stores.
// - locations 0x00 to 0x1f accept single-bit set and clear requests.
// - locations 0x00 to 0x1f answer a bit test that tells the core whether to skip.
// - port reads and writes use i/o addresses 0x00 to 0x3f.
// - a data-space address equals the i/o address plus 0x20.
// - the port window spans only 64 locations; further peripherals lie beyond it.
// - extended locations at data 0x60 to 0xbf answer data-space accesses only; 0xc0 to 0xff are reserved.
// - some status flags clear on a written one and ignore a written zero.
// - bit set and clear touch only the addressed bit and only at 0x00 to 0x1f.
`timescale 1ns/10ps

module iosad_decoder
  import iosad_pkg::*;
(
  input  wire logic                 clk_in,            // cpu clock, 10 MHz
  input  wire logic                 rst_n_in,          // async reset, active low
  input  wire iosad_pkg::iosad_op_e op_in,             // request kind, held one cycle
  input  wire logic [15:0]          addr_in,           // request address
  input  wire logic [2:0]           bit_in,            // bit number for bit requests
  input  wire logic [7:0]           wdata_in,          // store data
  input  wire logic [7:0]           periph_rdata_in,   // selected location's value
  output logic      [7:0]           periph_addr_out,   // i/o index of access
  output logic                      periph_rd_out,     // read strobe
  output logic                      periph_wr_out,     // write strobe
  output logic      [7:0]           periph_wdata_out,  // write data
  output logic      [7:0]           periph_wmask_out,  // bits the write may change
  output logic      [7:0]           rdata_out,         // load result
  output logic                      rvalid_out,        // load result valid
  output logic                      skip_out,          // skip next instruction
  output logic                      done_out,          // request finished
  output logic                      refused_out        // request hit nothing
);

  logic [7:0] map_idx;
  logic       map_hit;
  logic       map_rd;
  logic       map_wr;

  iosad_addr_map u_map (
    .op_in   (op_in),
    .addr_in (addr_in),
    .idx_out (map_idx),
    .hit_out (map_hit),
    .rd_out  (map_rd),
    .wr_out  (map_wr)
  );

  // stage one: peripheral strobes
  logic [7:0] next_periph_addr;
  logic       next_periph_rd;
  logic       next_periph_wr;
  logic [7:0] next_periph_wdata;
  logic [7:0] next_periph_wmask;
  iosad_op_e  pend_op;
  iosad_op_e  next_pend_op;
  logic [2:0] pend_bit;
  logic [2:0] next_pend_bit;
  logic       pend_hit;
  logic       next_pend_hit;
  logic [7:0] bit_onehot;

  always_comb
  begin
    bit_onehot        = IOSAD_MASK_BIT0 << bit_in;
    next_periph_addr  = IOSAD_RST_BYTE;
    next_periph_rd    = map_hit && map_rd;
    next_periph_wr    = map_hit && map_wr;
    next_periph_wdata = IOSAD_RST_BYTE;
    next_periph_wmask = IOSAD_RST_BYTE;
    next_pend_op      = op_in;
    next_pend_bit     = bit_in;
    next_pend_hit     = map_hit;
    if (map_hit && (map_rd || map_wr))
    begin
      next_periph_addr = map_idx;
    end
    if (map_hit && map_wr)
    begin
      case (op_in)
        // only the addressed lane is enabled, so w1c flags next to it
        // see no written one and keep their state
        IOSAD_OP_BIT_SET:
        begin
          next_periph_wmask = bit_onehot;
          next_periph_wdata = bit_onehot;
        end
        IOSAD_OP_BIT_CLR:
        begin
          next_periph_wmask = bit_onehot;
          next_periph_wdata = IOSAD_RST_BYTE;
        end
        default:
        begin
          // whole-byte stores pass data through; written ones clear flags there
          next_periph_wmask = IOSAD_MASK_ALL;
          next_periph_wdata = wdata_in;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      periph_addr_out  <= IOSAD_RST_BYTE;
      periph_rd_out    <= 1'b0;
      periph_wr_out    <= 1'b0;
      periph_wdata_out <= IOSAD_RST_BYTE;
      periph_wmask_out <= IOSAD_RST_BYTE;
      pend_op          <= IOSAD_OP_NONE;
      pend_bit         <= 3'h0;
      pend_hit         <= 1'b0;
    end
    else
    begin
      periph_addr_out  <= next_periph_addr;
      periph_rd_out    <= next_periph_rd;
      periph_wr_out    <= next_periph_wr;
      periph_wdata_out <= next_periph_wdata;
      periph_wmask_out <= next_periph_wmask;
      pend_op          <= next_pend_op;
      pend_bit         <= next_pend_bit;
      pend_hit         <= next_pend_hit;
    end
  end

  // stage two: answers to the core
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_skip;
  logic       next_done;
  logic       next_refused;
  logic [7:0] rd_value;

  always_comb
  begin
    // unmapped reads never reach a peripheral and return zero
    rd_value     = pend_hit ? periph_rdata_in : IOSAD_RST_BYTE;
    next_rdata   = IOSAD_RST_BYTE;
    next_rvalid  = 1'b0;
    next_skip    = 1'b0;
    next_done    = (pend_op != IOSAD_OP_NONE);
    next_refused = (pend_op != IOSAD_OP_NONE) && !pend_hit;
    case (pend_op)
      IOSAD_OP_PORT_RD, IOSAD_OP_DS_LOAD:
      begin
        next_rdata  = rd_value;
        next_rvalid = 1'b1;
      end
      IOSAD_OP_SKIP_SET:
      begin
        next_skip = pend_hit && rd_value[pend_bit];
      end
      IOSAD_OP_SKIP_CLR:
      begin
        next_skip = pend_hit && !rd_value[pend_bit];
      end
      default:
      begin
        next_rvalid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out   <= IOSAD_RST_BYTE;
      rvalid_out  <= 1'b0;
      skip_out    <= 1'b0;
      done_out    <= 1'b0;
      refused_out <= 1'b0;
    end
    else
    begin
      rdata_out   <= next_rdata;
      rvalid_out  <= next_rvalid;
      skip_out    <= next_skip;
      done_out    <= next_done;
      refused_out <= next_refused;
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_load_req;
    (op_in == IOSAD_OP_DS_LOAD) && map_hit;
  endsequence

  sequence s_port_req;
    ((op_in == IOSAD_OP_PORT_RD) || (op_in == IOSAD_OP_PORT_WR)) && map_hit;
  endsequence

  sequence s_skip_set_seen;
    (op_in == IOSAD_OP_SKIP_SET) && map_hit ##1 periph_rdata_in[pend_bit];
  endsequence

  ds_load_path_a: assert property (
    s_load_req ##1 periph_rd_out ##1 1'b1 |-> rvalid_out && (rdata_out == $past(periph_rdata_in)))
    else $error("load result does not follow peripheral data");

  ds_offset_a: assert property (
    s_load_req |=> periph_addr_out == ($past(addr_in[7:0]) - 8'h20))
    else $error("data address not offset by 0x20");

  port_window_a: assert property (
    s_port_req |=> (periph_rd_out || periph_wr_out) && (periph_addr_out == $past(addr_in[7:0])))
    else $error("port access selected wrong location");

  port_limit_a: assert property (
    (op_in == IOSAD_OP_PORT_WR) && (addr_in > 16'h003f) |=> !periph_wr_out)
    else $error("port write beyond 64 locations");

  ext_data_only_a: assert property (
    (op_in == IOSAD_OP_DS_STORE) && (addr_in >= 16'h0060) && (addr_in <= 16'h00ff)
      && IOSAD_IMPL_MAP[map_idx] |=> periph_wr_out && (periph_addr_out >= 8'h40))
    else $error("extended store did not reach its location");

  bit_single_a: assert property (
    (op_in == IOSAD_OP_BIT_CLR) && map_hit |=> periph_wr_out && ($countones(periph_wmask_out) == 1)
      && (periph_wmask_out == (8'h01 << $past(bit_in))) && (periph_wdata_out == 8'h00))
    else $error("bit clear touches other bits");

  bit_range_a: assert property (
    ((op_in == IOSAD_OP_BIT_SET) || (op_in == IOSAD_OP_BIT_CLR)) && (addr_in > 16'h001f)
      |=> !periph_wr_out ##1 refused_out)
    else $error("bit write above 0x1f accepted");

  skip_test_a: assert property (
    s_skip_set_seen |=> skip_out)
    else $error("skip not raised for set bit");

  unmapped_read_a: assert property (
    (op_in == IOSAD_OP_PORT_RD) && !map_hit |=> !periph_rd_out ##1 rvalid_out && (rdata_out == 8'h00))
    else $error("unmapped read did not return zero");

  set_bit_data_a: assert property (
    (op_in == IOSAD_OP_BIT_SET) && map_hit |=> (periph_wdata_out & ~periph_wmask_out) == 8'h00)
    else $error("bit set writes ones outside its lane");

endmodule // iosad_decoder

// ===== logic/iosad_pkg.sv
// constants and types shared by the i/o space address decoder
package iosad_pkg;

  // request kinds issued by the core
  typedef enum logic [3:0] {
    IOSAD_OP_NONE,
    IOSAD_OP_PORT_RD,
    IOSAD_OP_PORT_WR,
    IOSAD_OP_DS_LOAD,
    IOSAD_OP_DS_STORE,
    IOSAD_OP_BIT_SET,
    IOSAD_OP_BIT_CLR,
    IOSAD_OP_SKIP_SET,
    IOSAD_OP_SKIP_CLR
  } iosad_op_e;

  localparam logic [7:0]   IOSAD_DS_OFFSET  = 8'h20;  // data address minus i/o address
  localparam logic [15:0]  IOSAD_PORT_LAST  = 16'h003f;
  localparam logic [15:0]  IOSAD_BIT_LAST   = 16'h001f;
  localparam logic [15:0]  IOSAD_DS_FIRST   = 16'h0020;
  localparam logic [15:0]  IOSAD_EXT_FIRST  = 16'h0060;
  localparam logic [15:0]  IOSAD_EXT_LAST   = 16'h00ff;
  localparam int           IOSAD_IO_COUNT   = 224;
  localparam logic [7:0]   IOSAD_RST_BYTE   = 8'h00;
  localparam logic [7:0]   IOSAD_MASK_ALL   = 8'hff;
  localparam logic [7:0]   IOSAD_MASK_BIT0  = 8'h01;
  // one bit per i/o index; clear bits are reserved locations
  localparam logic [IOSAD_IO_COUNT-1:0] IOSAD_IMPL_MAP = {64'h0, {160{1'b1}}};

endpackage

// ===== logic/iosad_addr_map.sv
// maps a core request onto an i/o index and decides whether it may proceed
`timescale 1ns/10ps

module iosad_addr_map
  import iosad_pkg::*;
(
  input  wire iosad_pkg::iosad_op_e op_in,    // request kind
  input  wire logic [15:0]          addr_in,  // port, bit or data address
  output logic      [7:0]           idx_out,  // i/o index 0x00..0xdf
  output logic                      hit_out,  // legal and implemented
  output logic                      rd_out,   // request reads the location
  output logic                      wr_out    // request writes the location
);

  logic in_range;

  always_comb
  begin
    idx_out  = 8'h00;
    in_range = 1'b0;
    rd_out   = 1'b0;
    wr_out   = 1'b0;
    case (op_in)
      IOSAD_OP_PORT_RD, IOSAD_OP_PORT_WR:
      begin
        // port opcode field holds only six address bits
        in_range = (addr_in <= IOSAD_PORT_LAST);
        idx_out  = {2'b00, addr_in[5:0]};
        rd_out   = (op_in == IOSAD_OP_PORT_RD);
        wr_out   = (op_in == IOSAD_OP_PORT_WR);
      end
      IOSAD_OP_DS_LOAD, IOSAD_OP_DS_STORE:
      begin
        // below 0x20 is the working register file, not ours
        in_range = (addr_in >= IOSAD_DS_FIRST) && (addr_in <= IOSAD_EXT_LAST);
        idx_out  = addr_in[7:0] - IOSAD_DS_OFFSET;
        rd_out   = (op_in == IOSAD_OP_DS_LOAD);
        wr_out   = (op_in == IOSAD_OP_DS_STORE);
      end
      IOSAD_OP_BIT_SET, IOSAD_OP_BIT_CLR, IOSAD_OP_SKIP_SET, IOSAD_OP_SKIP_CLR:
      begin
        in_range = (addr_in <= IOSAD_BIT_LAST);
        idx_out  = {3'b000, addr_in[4:0]};
        rd_out   = (op_in == IOSAD_OP_SKIP_SET) || (op_in == IOSAD_OP_SKIP_CLR);
        wr_out   = (op_in == IOSAD_OP_BIT_SET) || (op_in == IOSAD_OP_BIT_CLR);
      end
      default:
      begin
        in_range = 1'b0;
      end
    endcase
    hit_out = in_range && IOSAD_IMPL_MAP[idx_out];
  end

endmodule // iosad_addr_map

// ===== tb/iosad_periph_model.sv
// peripheral register file model answering the decoder's strobes
`timescale 1ns/10ps

module iosad_periph_model
  import iosad_pkg::*;
#(
  parameter logic [7:0] W1C_IDX = 8'h07  // location holding write-one-to-clear flags
)
(
  input  wire logic       clk_in,    // cpu clock
  input  wire logic       rst_n_in,  // async reset, active low
  input  wire logic [7:0] addr_in,   // i/o index
  input  wire logic       rd_in,     // read strobe
  input  wire logic       wr_in,     // write strobe
  input  wire logic [7:0] wdata_in,  // write data
  input  wire logic [7:0] wmask_in,  // lanes the write may change
  output logic      [7:0] rdata_out  // selected value
);
  logic [7:0] mem [0:255];
  logic [7:0] last;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < 256; i++)
        mem[i] <= 8'h00;
      // flags pending after reset so clearing can be seen
      mem[W1C_IDX] <= 8'hff;
      last <= 8'h00;
    end
    else
    begin
      if (rd_in)
        last <= mem[addr_in];
      if (wr_in)
        for (int i = 0; i < 8; i++)
          if (wmask_in[i])
            mem[addr_in][i] <= (addr_in == W1C_IDX) ? (mem[addr_in][i] & ~wdata_in[i])
                                                    : wdata_in[i];
    end
  end

  // idle bus shows the inverse of the last value so stale data never matches
  assign rdata_out = rd_in ? mem[addr_in] : ~last;
endmodule // iosad_periph_model

// ===== tb/iosad_decoder_tb.sv
// self-checking bench for the i/o space address decoder
`timescale 1ns/10ps

module iosad_decoder_tb;
  import iosad_pkg::*;
  logic        clk_in;
  logic        rst_n_in;
  iosad_op_e   op_in;
  logic [15:0] addr_in;
  logic [2:0]  bit_in;
  logic [7:0]  wdata_in, p_rdata, p_addr, p_wdata, p_wmask, rdata;
  logic        p_rd, p_wr, rvalid, skip, done, refused;
  int          fail_count;
  int          tests_run;

  iosad_decoder iosad_decoder_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .op_in(op_in),
    .addr_in(addr_in), .bit_in(bit_in), .wdata_in(wdata_in), .periph_rdata_in(p_rdata),
    .periph_addr_out(p_addr), .periph_rd_out(p_rd), .periph_wr_out(p_wr),
    .periph_wdata_out(p_wdata), .periph_wmask_out(p_wmask), .rdata_out(rdata),
    .rvalid_out(rvalid), .skip_out(skip), .done_out(done), .refused_out(refused));

  iosad_periph_model iosad_periph_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(p_addr), .rd_in(p_rd), .wr_in(p_wr), .wdata_in(p_wdata),
    .wmask_in(p_wmask), .rdata_out(p_rdata));

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // entered at a falling edge; returns at the falling edge after done
  task automatic req(input iosad_op_e op, input logic [15:0] a, input logic [2:0] b,
                     input logic [7:0] wd, input logic exp_ref);
    int n;
    n = 0;
    op_in = op;
    addr_in = a;
    bit_in = b;
    wdata_in = wd;
    @(negedge clk_in);
    op_in = IOSAD_OP_NONE;
    while (done !== 1'b1 && n < 4)
    begin
      @(negedge clk_in);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    if (done !== 1'b1)
      close_out();
    chk("refused", {7'h00, exp_ref}, {7'h00, refused});
  endtask

  task automatic rd(input iosad_op_e op, input logic [15:0] a, input logic [7:0] exp,
                    input logic exp_ref);
    req(op, a, 3'h0, 8'h00, exp_ref);
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", exp, rdata);
  endtask

  task automatic sk(input iosad_op_e op, input logic [15:0] a, input logic [2:0] b,
                    input logic exp, input logic exp_ref);
    req(op, a, b, 8'h00, exp_ref);
    chk("skip", {7'h00, exp}, {7'h00, skip});
  endtask

  task automatic t_port();
    req(IOSAD_OP_PORT_WR, 16'h003f, 3'h0, 8'h5a, 1'b0);
    rd(IOSAD_OP_PORT_RD, 16'h003f, 8'h5a, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h005f, 8'h5a, 1'b0);
    req(IOSAD_OP_PORT_WR, 16'h0040, 3'h0, 8'h33, 1'b1);
    rd(IOSAD_OP_PORT_RD, 16'h0040, 8'h00, 1'b1);
  endtask

  task automatic t_data();
    req(IOSAD_OP_DS_STORE, 16'h0025, 3'h0, 8'hc3, 1'b0);
    rd(IOSAD_OP_PORT_RD, 16'h0005, 8'hc3, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h001f, 8'h00, 1'b1);
    req(IOSAD_OP_DS_STORE, 16'h0060, 3'h0, 8'h11, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h0060, 8'h11, 1'b0);
    req(IOSAD_OP_BIT_SET, 16'h0040, 3'h1, 8'h00, 1'b1);
    sk(IOSAD_OP_SKIP_CLR, 16'h0040, 3'h1, 1'b0, 1'b1);
    rd(IOSAD_OP_DS_LOAD, 16'h0100, 8'h00, 1'b1);
  endtask

  task automatic t_bit();
    req(IOSAD_OP_DS_STORE, 16'h0023, 3'h0, 8'h00, 1'b0);
    req(IOSAD_OP_BIT_SET, 16'h0003, 3'h2, 8'h00, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h0023, 8'h04, 1'b0);
    req(IOSAD_OP_BIT_SET, 16'h0003, 3'h7, 8'h00, 1'b0);
    req(IOSAD_OP_BIT_CLR, 16'h0003, 3'h2, 8'h00, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h0023, 8'h80, 1'b0);
    req(IOSAD_OP_BIT_SET, 16'h001f, 3'h0, 8'h00, 1'b0);
    rd(IOSAD_OP_PORT_RD, 16'h001f, 8'h01, 1'b0);
    // a bit request at io 0x20 would alias onto index 0x00 if the range check failed
    req(IOSAD_OP_DS_STORE, 16'h0020, 3'h0, 8'h00, 1'b0);
    req(IOSAD_OP_BIT_SET, 16'h0020, 3'h0, 8'h00, 1'b1);
    rd(IOSAD_OP_DS_LOAD, 16'h0020, 8'h00, 1'b0);
  endtask

  task automatic t_w1c();
    rd(IOSAD_OP_DS_LOAD, 16'h0027, 8'hff, 1'b0);
    req(IOSAD_OP_BIT_SET, 16'h0007, 3'h1, 8'h00, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h0027, 8'hfd, 1'b0);
    req(IOSAD_OP_DS_STORE, 16'h0027, 3'h0, 8'h00, 1'b0);
    req(IOSAD_OP_PORT_WR, 16'h0007, 3'h0, 8'h01, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h0027, 8'hfc, 1'b0);
  endtask

  task automatic t_skip();
    sk(IOSAD_OP_SKIP_SET, 16'h0003, 3'h7, 1'b1, 1'b0);
    sk(IOSAD_OP_SKIP_CLR, 16'h0003, 3'h7, 1'b0, 1'b0);
    sk(IOSAD_OP_SKIP_CLR, 16'h0003, 3'h0, 1'b1, 1'b0);
    sk(IOSAD_OP_SKIP_SET, 16'h0003, 3'h0, 1'b0, 1'b0);
    sk(IOSAD_OP_SKIP_SET, 16'h0020, 3'h0, 1'b0, 1'b1);
  endtask

  task automatic t_rsvd();
    // software never stores to a reserved location, so the ignored store goes
    // above the window instead; it would alias onto index 0x00 if accepted
    req(IOSAD_OP_DS_STORE, 16'h0120, 3'h0, 8'h77, 1'b1);
    rd(IOSAD_OP_DS_LOAD, 16'h0020, 8'h00, 1'b0);
    rd(IOSAD_OP_DS_LOAD, 16'h00c0, 8'h00, 1'b1);
    rd(IOSAD_OP_DS_LOAD, 16'h00bf, 8'h00, 1'b0);
  endtask

  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rst_n_in = 1'b0;
    op_in = IOSAD_OP_NONE;
    addr_in = 16'h0000;
    bit_in = 3'h0;
    wdata_in = 8'h00;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    t_port();
    t_data();
    t_bit();
    t_w1c();
    t_skip();
    t_rsvd();
    close_out();
  end
endmodule // iosad_decoder_tb
